// >>> fcfsm_pkg.sv
package fcfsm_pkg;

  // occupancy, address, data and event widths
  localparam int unsigned OCC_W    = 8;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned EVT_W    = 4;

  // occupancy limits of the queue
  localparam logic [OCC_W-1:0] OCC_EMPTY = 8'h00;
  localparam logic [OCC_W-1:0] OCC_FULL  = 8'hFA;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h0C;

  // status register field positions
  localparam int unsigned STAT_IND_LSB   = 0;
  localparam int unsigned STAT_EFLAG_BIT = 5;
  localparam int unsigned STAT_FFLAG_BIT = 6;
  localparam int unsigned STAT_OCC_LSB   = 8;

  // control register field positions
  localparam int unsigned CTRL_FREEZE_BIT = 0;

  // interrupt event bit positions
  localparam int unsigned EVT_ENTER_EMPTY = 0;
  localparam int unsigned EVT_ENTER_FULL  = 1;
  localparam int unsigned EVT_REFUSED     = 2;
  localparam int unsigned EVT_BOTH_REQ    = 3;

  // values after reset
  localparam logic [EVT_W-1:0]  RST_IRQ_MASK = 4'h0;
  localparam logic              RST_FREEZE   = 1'b0;
  localparam logic [DATA_W-1:0] RST_RDATA    = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_EMPTY,
    ST_FULL,
    ST_IDLE,
    ST_DRAIN,
    ST_FILL
  } fcfsm_state_e;

  typedef struct packed {
    logic push;
    logic pop;
  } fcfsm_req_s;

  typedef struct packed {
    logic fill;
    logic drain;
    logic idle;
    logic full;
    logic empty;
  } fcfsm_ind_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              we;
    logic              re;
  } fcfsm_bus_s;

  localparam fcfsm_ind_s RST_IND = 5'h01;

endpackage

// >>> fcfsm_sticky.sv
`timescale 1ns/100ps

module fcfsm_sticky
  import fcfsm_pkg::*;
#(
  parameter int unsigned WIDTH = 4
)
(
  // clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             reset_n_i,
  // set and write-one-to-clear
  input  wire logic [WIDTH-1:0] set_i,
  input  wire logic [WIDTH-1:0] clr_i,
  // held bits
  output logic      [WIDTH-1:0] bits_o
);

  logic [WIDTH-1:0] bits_reg;
  logic [WIDTH-1:0] bits_next;

  // set wins so an event in the clearing cycle survives
  assign bits_next = (bits_reg & ~clr_i) | set_i;

  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
      bits_reg <= '0;
    else
      bits_reg <= bits_next;
  end

  assign bits_o = bits_reg;

endmodule // fcfsm_sticky

// >>> fcfsm_ctrl.sv
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/100ps

// What this block does
// (RULE_01) Occupancy arrives as an 8-bit unsigned count covering 0 to 250.
// (RULE_02) Reset is synchronous and every output comes from a flip-flop.
// (RULE_03) Reset puts the machine in the empty state, its default state.
// (RULE_04) Empty goes to filling on push below 250, to idle with no request.
// (RULE_05) Full goes to draining on pop and to idle with no request.
// (RULE_06) Idle goes on pop to empty or draining, on push to full or filling.
// (RULE_07) Draining goes idle, empty, stays, full or filling per request.
// (RULE_08) Filling goes idle, full, stays, empty or draining per request.
// (RULE_09) One indicator per state is high only in its own state.
// (RULE_10) A push below 250 increments the counter and writes a byte.
// (RULE_11) A pop above 0 decrements the counter and reads a byte.
// (RULE_12) The empty flag is high exactly when the count is zero.
// (RULE_13) The full flag is high exactly when the count is 250.
// (RULE_14) The more specific condition wins: push at 250 gives full.
// (RULE_15) With no matching condition the machine keeps its state.
// (RULE_16) The requester never raises push and pop in the same cycle; the test raises both once, while frozen, to set EVT_BOTH_REQ.

module fcfsm_ctrl
  import fcfsm_pkg::*;
(
  // clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              reset_n_i,
  // queue requests and counter occupancy
  input  wire fcfsm_req_s        req_i,
  input  wire logic [OCC_W-1:0]  occupancy_i,
  // register port
  input  wire fcfsm_bus_s        bus_i,
  output logic      [DATA_W-1:0] rdata_o,
  // state indicators and occupancy flags
  output fcfsm_ind_s             ind_o,
  output logic                   empty_flag_o,
  output logic                   full_flag_o,
  // counter and ram controls
  output logic                   count_up_o,
  output logic                   count_dn_o,
  output logic                   ram_we_o,
  output logic                   ram_re_o,
  // interrupt
  output logic                   irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // decode of requests and occupancy

  wire logic push_w;
  wire logic pop_w;
  wire logic none_w;
  wire logic at_full_w;
  wire logic at_empty_w;

  assign push_w     = req_i.push;
  assign pop_w      = req_i.pop;
  assign none_w     = !push_w && !pop_w;
  assign at_full_w  = (occupancy_i == OCC_FULL);  // [RULE_01]
  assign at_empty_w = (occupancy_i == OCC_EMPTY); // [RULE_01]

  ////////////////////////////////////////////////////////////////////////////
  // state machine

  fcfsm_state_e state_reg;
  fcfsm_state_e state_next;
  fcfsm_state_e step_w;
  logic         freeze_reg;

  always_comb
  begin
    step_w = state_reg;
    case (state_reg)
      ST_EMPTY:
      begin
        // pop here and push at 250 are not listed, so stay
        if (none_w)
          step_w = ST_IDLE;                         // [RULE_04]
        else if (push_w && !at_full_w)
          step_w = ST_FILL;                         // [RULE_04] [RULE_15]
      end
      ST_FULL:
      begin
        // pop checked first; a push alone keeps full
        if (pop_w)
          step_w = ST_DRAIN;                        // [RULE_05]
        else if (none_w)
          step_w = ST_IDLE;                         // [RULE_05] [RULE_15]
      end
      ST_IDLE:
      begin
        if (pop_w)
          step_w = at_empty_w ? ST_EMPTY : ST_DRAIN; // [RULE_06] [RULE_14]
        else if (push_w)
          step_w = at_full_w ? ST_FULL : ST_FILL;   // [RULE_06] [RULE_14]
      end
      ST_DRAIN:
      begin
        if (none_w)
          step_w = ST_IDLE;                         // [RULE_07]
        else if (pop_w)
          step_w = at_empty_w ? ST_EMPTY : ST_DRAIN; // [RULE_07] [RULE_14]
        else
          step_w = at_full_w ? ST_FULL : ST_FILL;   // [RULE_07] [RULE_14]
      end
      ST_FILL:
      begin
        if (none_w)
          step_w = ST_IDLE;                         // [RULE_08]
        else if (push_w)
          step_w = at_full_w ? ST_FULL : ST_FILL;   // [RULE_08] [RULE_14]
        else
          step_w = at_empty_w ? ST_EMPTY : ST_DRAIN; // [RULE_08] [RULE_14]
      end
      default:
        step_w = ST_EMPTY;
    endcase
  end

  // freeze holds the machine so software can inspect a stable state
  assign state_next = freeze_reg ? state_reg : step_w;

  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
      state_reg <= ST_EMPTY;                        // [RULE_02] [RULE_03]
    else
      state_reg <= state_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs: indicators follow state_next so they match state_reg

  wire fcfsm_ind_s ind_next;
  fcfsm_ind_s ind_reg;
  logic       eflag_reg;
  logic       fflag_reg;
  logic       up_reg;
  logic       dn_reg;

  assign ind_next.empty = (state_next == ST_EMPTY); // [RULE_09]
  assign ind_next.full  = (state_next == ST_FULL);  // [RULE_09]
  assign ind_next.idle  = (state_next == ST_IDLE);  // [RULE_09]
  assign ind_next.drain = (state_next == ST_DRAIN); // [RULE_09]
  assign ind_next.fill  = (state_next == ST_FILL);  // [RULE_09]

  wire logic up_next;
  wire logic dn_next;

  // counter commands are not gated by freeze: the queue keeps moving data
  assign up_next = push_w && (occupancy_i < OCC_FULL);  // [RULE_10]
  assign dn_next = pop_w && (occupancy_i > OCC_EMPTY);  // [RULE_11]

  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      ind_reg   <= RST_IND;                         // [RULE_03]
      eflag_reg <= 1'b1;
      fflag_reg <= 1'b0;
      up_reg    <= 1'b0;
      dn_reg    <= 1'b0;
    end
    else
    begin
      ind_reg   <= ind_next;                        // [RULE_02]
      eflag_reg <= at_empty_w;                      // [RULE_12]
      fflag_reg <= at_full_w;                       // [RULE_13]
      up_reg    <= up_next;                         // [RULE_10]
      dn_reg    <= dn_next;                         // [RULE_11]
    end
  end

  assign ind_o        = ind_reg;
  assign empty_flag_o = eflag_reg;
  assign full_flag_o  = fflag_reg;
  assign count_up_o   = up_reg;
  assign ram_we_o     = up_reg;
  assign count_dn_o   = dn_reg;
  assign ram_re_o     = dn_reg;

  ////////////////////////////////////////////////////////////////////////////
  // events and interrupt

  wire logic [EVT_W-1:0] evt_w;
  wire logic [EVT_W-1:0] evt_clr_w;
  wire logic [EVT_W-1:0] irq_stat_w;
  logic      [EVT_W-1:0] mask_reg;
  logic                  irq_reg;
  wire logic             irq_next_w = |(irq_stat_w & mask_reg);
  assign evt_w[EVT_ENTER_EMPTY] = ind_next.empty && !ind_reg.empty;
  assign evt_w[EVT_ENTER_FULL]  = ind_next.full && !ind_reg.full;
  // a request the machine cannot act on in its current state
  assign evt_w[EVT_REFUSED]     = (ind_reg.full && push_w && !pop_w)
                               || (ind_reg.empty && pop_w && !push_w);
  assign evt_w[EVT_BOTH_REQ]    = push_w && pop_w;

  wire logic sel_stat_w;
  wire logic sel_irq_w;
  wire logic sel_mask_w;
  wire logic sel_ctrl_w;

  assign sel_stat_w = (bus_i.addr == OFS_STATUS);
  assign sel_irq_w  = (bus_i.addr == OFS_IRQ_STAT);
  assign sel_mask_w = (bus_i.addr == OFS_IRQ_MASK);
  assign sel_ctrl_w = (bus_i.addr == OFS_CTRL);

  assign evt_clr_w = (bus_i.we && sel_irq_w) ? bus_i.wdata[EVT_W-1:0]
                                             : '0;

  fcfsm_sticky #(
    .WIDTH (EVT_W)
  ) u_irq_stat (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .set_i      (evt_w),
    .clr_i      (evt_clr_w),
    .bits_o     (irq_stat_w)
  );

  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
      irq_reg <= 1'b0;
    else
      irq_reg <= irq_next_w;
  end

  assign irq_o = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // register port

  logic              freeze_next;
  logic [EVT_W-1:0]  mask_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic [DATA_W-1:0] stat_word_w;

  always_comb
  begin
    stat_word_w = '0;
    stat_word_w[STAT_IND_LSB +: 5]          = ind_reg;
    stat_word_w[STAT_EFLAG_BIT]             = eflag_reg;
    stat_word_w[STAT_FFLAG_BIT]             = fflag_reg;
    stat_word_w[STAT_OCC_LSB +: OCC_W]      = occupancy_i;
  end

  assign mask_next   = (bus_i.we && sel_mask_w) ? bus_i.wdata[EVT_W-1:0]
                                                : mask_reg;
  assign freeze_next = (bus_i.we && sel_ctrl_w)
                     ? bus_i.wdata[CTRL_FREEZE_BIT] : freeze_reg;

  // unmapped reads and idle cycles return zero
  always_comb
  begin
    rdata_next = '0;
    if (bus_i.re)
    begin
      if (sel_stat_w)
        rdata_next = stat_word_w;
      else if (sel_irq_w)
        rdata_next[EVT_W-1:0] = irq_stat_w;
      else if (sel_mask_w)
        rdata_next[EVT_W-1:0] = mask_reg;
      else if (sel_ctrl_w)
        rdata_next[CTRL_FREEZE_BIT] = freeze_reg;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      mask_reg   <= RST_IRQ_MASK;
      freeze_reg <= RST_FREEZE;
      rdata_reg  <= RST_RDATA;
    end
    else
    begin
      mask_reg   <= mask_next;
      freeze_reg <= freeze_next;
      rdata_reg  <= rdata_next;
    end
  end

  assign rdata_o = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  AST_RESET_EMPTY: assert property ( // [RULE_03]
    @(posedge core_clk_i) !reset_n_i |=> (ind_o == RST_IND)
  ) else $error("reset did not select the empty state");

  AST_ONE_HOT: assert property ( // [RULE_09]
    @(posedge core_clk_i) disable iff (!reset_n_i)
    $onehot(ind_o) && (ind_o.empty == (state_reg == ST_EMPTY))
      && (ind_o.fill == (state_reg == ST_FILL))
  ) else $error("state indicators do not match the state");

  AST_IDLE_ON_NONE: assert property ( // [RULE_04] [RULE_05] [RULE_07]
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (!freeze_reg && none_w) |=> ind_o.idle && !ind_o.empty
  ) else $error("no request did not lead to idle");

  AST_FULL_ON_PUSH: assert property ( // [RULE_14]
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (!freeze_reg && push_w && !pop_w && at_full_w && !ind_o.empty)
      |=> ind_o.full
  ) else $error("push at 250 did not select full");

  AST_EMPTY_ON_POP: assert property ( // [RULE_06] [RULE_08]
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (!freeze_reg && pop_w && !push_w && at_empty_w && !ind_o.full)
      |=> ind_o.empty
  ) else $error("pop at zero did not select empty");

  AST_FULL_TO_DRAIN: assert property ( // [RULE_05]
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (!freeze_reg && ind_o.full && pop_w) |=> ind_o.drain
  ) else $error("pop in full did not select draining");

  AST_FULL_PUSH_STAYS: assert property ( // [RULE_15]
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (!freeze_reg && ind_o.full && push_w && !pop_w) |=> $stable(ind_o)
  ) else $error("push in full changed the state");

  AST_COUNT_UP: assert property ( // [RULE_10]
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (push_w && !pop_w) |=> (count_up_o == ($past(occupancy_i) < OCC_FULL))
      && ram_we_o == count_up_o && !count_dn_o
  ) else $error("increment and write do not follow push");

  AST_COUNT_DN: assert property ( // [RULE_11]
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (pop_w && !push_w) |=> (count_dn_o == ($past(occupancy_i) != OCC_EMPTY))
      && ram_re_o == count_dn_o && !count_up_o
  ) else $error("decrement and read do not follow pop");

  AST_FLAGS: assert property ( // [RULE_12] [RULE_13]
    @(posedge core_clk_i) disable iff (!reset_n_i)
    ##1 (empty_flag_o == ($past(occupancy_i) == 8'h00))
      && (full_flag_o == ($past(occupancy_i) == 8'hFA))
  ) else $error("occupancy flags wrong");

  AST_IRQ_LEVEL: assert property ( // [RULE_02]
    @(posedge core_clk_i) disable iff (!reset_n_i)
    ##1 irq_o == $past(irq_next_w)
  ) else $error("interrupt does not follow masked status");

endmodule // fcfsm_ctrl

// >>> fcfsm_queue_model.sv
`timescale 1ns/100ps

module fcfsm_queue_model
  import fcfsm_pkg::*;
(
  // clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             reset_n_i,
  // counter and ram controls from the controller
  input  wire logic             count_up_i,
  input  wire logic             count_dn_i,
  input  wire logic             ram_we_i,
  input  wire logic             ram_re_i,
  input  wire logic [7:0]       wbyte_i,
  // occupancy and read byte
  output logic      [OCC_W-1:0] occupancy_o,
  output logic      [7:0]       rbyte_o
);
  logic [7:0] mem [0:255];

  // counter saturates: controls lag the occupancy by one cycle
  always_ff @(posedge core_clk_i)
    if (!reset_n_i)
      occupancy_o <= OCC_EMPTY;
    else if (count_up_i && !count_dn_i && occupancy_o < OCC_FULL)
      occupancy_o <= occupancy_o + 8'h01;
    else if (count_dn_i && !count_up_i && occupancy_o != OCC_EMPTY)
      occupancy_o <= occupancy_o - 8'h01;

  always_ff @(posedge core_clk_i)
  begin
    if (ram_we_i)
      mem[occupancy_o] <= wbyte_i;
    if (ram_re_i)
      rbyte_o <= mem[occupancy_o - 8'h01];
  end
endmodule // fcfsm_queue_model

// >>> fcfsm_ctrl_test.sv
`timescale 1ns/100ps

module fcfsm_ctrl_test
  import fcfsm_pkg::*;
;
  logic              core_clk;
  logic              reset_n;
  fcfsm_req_s        req;
  fcfsm_bus_s        bus;
  fcfsm_ind_s        ind;
  logic [OCC_W-1:0]  occ;
  logic [DATA_W-1:0] rdata;
  logic [7:0]        wbyte;
  logic              empty_flag;
  logic              full_flag;
  logic              cnt_up;
  logic              cnt_dn;
  logic              ram_we;
  logic              ram_re;
  logic              irq;
  int                bad_count;
  int                n_checks;
  int                seed;
  int                m_state;
  logic              m_frz;
  logic              m_valid;
  logic [31:0]       e_ind;
  logic [31:0]       e_ef;
  logic [31:0]       e_ff;
  logic [31:0]       e_up;
  logic [31:0]       e_dn;

  fcfsm_ctrl u_dut (
    .core_clk_i   (core_clk),
    .reset_n_i    (reset_n),
    .req_i        (req),
    .occupancy_i  (occ),
    .bus_i        (bus),
    .rdata_o      (rdata),
    .ind_o        (ind),
    .empty_flag_o (empty_flag),
    .full_flag_o  (full_flag),
    .count_up_o   (cnt_up),
    .count_dn_o   (cnt_dn),
    .ram_we_o     (ram_we),
    .ram_re_o     (ram_re),
    .irq_o        (irq)
  );

  fcfsm_queue_model u_queue (
    .core_clk_i  (core_clk),
    .reset_n_i   (reset_n),
    .count_up_i  (cnt_up),
    .count_dn_i  (cnt_dn),
    .ram_we_i    (ram_we),
    .ram_re_i    (ram_re),
    .wbyte_i     (wbyte),
    .occupancy_o (occ),
    .rbyte_o     ()
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic step(input logic pu, input logic po);
    req.push <= pu;
    req.pop  <= po;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.we    <= 1'b1;
    @(posedge core_clk);
    bus.we    <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus.addr <= a;
    bus.re   <= 1'b1;
    @(posedge core_clk);
    bus.re   <= 1'b0;
    #1 check("rdata", rdata, e);
    @(posedge core_clk);
  endtask

  task automatic chk_irq(input logic e);
    repeat (2) @(posedge core_clk);
    #1 check("irq", {31'h0, irq}, {31'h0, e});
    @(posedge core_clk);
  endtask

  // reference: 0 empty, 1 full, 2 idle, 3 drain, 4 fill
  function automatic int nxt(int s, logic pu, logic po, logic [7:0] o);
    if (!pu && !po)
      return 2;
    if (po)
      return (s == 1) ? 3 : (s == 0 || o == OCC_EMPTY) ? 0 : 3;
    return (s == 1) ? 1 : (o == OCC_FULL) ? ((s == 0) ? 0 : 1) : 4;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // outputs still hold last edge's values here; compare, then advance
  always @(posedge core_clk)
  begin
    if (m_valid)
    begin
      check("ind", {27'h0, ind}, e_ind);
      check("ind", {27'h0, ind}, e_ind);
      check("ind", {27'h0, ind}, e_ind);
      check("eflag", {31'h0, empty_flag}, e_ef);
      check("fflag", {31'h0, full_flag}, e_ff);
      check("up", {31'h0, cnt_up}, e_up);
      check("we", {31'h0, ram_we}, e_up);
      check("dn", {31'h0, cnt_dn}, e_dn);
      check("re", {31'h0, ram_re}, e_dn);
    end
    if (!reset_n)
    begin
      m_state = 0;
      m_frz = 1'b0;
    end
    else
    begin
      if (!m_frz)
        m_state = nxt(m_state, req.push, req.pop, occ);
      if (bus.we && bus.addr == OFS_CTRL)
        m_frz = bus.wdata[CTRL_FREEZE_BIT];
    end
    e_ind = 32'h1 << m_state;
    e_ef = {31'h0, !reset_n || occ == OCC_EMPTY};
    e_ff = {31'h0, reset_n && occ == OCC_FULL};
    e_up = {31'h0, reset_n && req.push && occ < OCC_FULL};
    e_dn = {31'h0, reset_n && req.pop && occ != OCC_EMPTY};
    m_valid = 1'b1;
  end

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  initial
  begin
    #(100 * 6000);
    bad_count++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    int pth[3];
    int qth[3];
    logic [31:0] v;
    pth = '{100, 20, 55};
    qth = '{120, 120, 110};
    seed = 91122;
    bad_count = 0;
    n_checks = 0;
    m_valid = 1'b0;
    reset_n = 1'b0;
    req = '0;
    bus = '0;
    wbyte = 8'h00;
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    rd(OFS_STATUS, 32'h0000_0024);
    rd(OFS_IRQ_STAT, 32'h0);
    rd(OFS_IRQ_MASK, 32'h0);
    rd(OFS_CTRL, 32'h0);
    wr(8'h10, 32'hFFFF_FFFF);
    rd(8'h10, 32'h0);
    for (int p = 0; p < 3; p++)
    begin
      for (int i = 0; i < 600; i++)
      begin
        v = $random(seed);
        wbyte <= v[15:8];
        step(v[6:0] < pth[p], v[6:0] >= pth[p] && v[6:0] < qth[p]);
      end
      if (p == 0)
      begin
        // fill to the top, then provoke entry into full and refusal
        repeat (260) step(1'b1, 1'b0);
        repeat (2) step(1'b0, 1'b0);
        wr(OFS_IRQ_STAT, 32'hF);
        rd(OFS_IRQ_STAT, 32'h0);
        repeat (2) step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        rd(OFS_IRQ_STAT, 32'h6);
      end
      if (p == 1)
      begin
        // drain fully, then provoke entry and refusal events
        repeat (260) step(1'b0, 1'b1);
        repeat (2) step(1'b0, 1'b0);
        wr(OFS_IRQ_STAT, 32'hF);
        rd(OFS_IRQ_STAT, 32'h0);
        repeat (2) step(1'b0, 1'b1);
        repeat (2) step(1'b0, 1'b0);
        rd(OFS_IRQ_STAT, 32'h5);
        wr(OFS_IRQ_MASK, 32'h4);
        chk_irq(1'b1);
        wr(OFS_IRQ_STAT, 32'h4);
        chk_irq(1'b0);
        wr(OFS_IRQ_MASK, 32'h1);
        chk_irq(1'b1);
        wr(OFS_IRQ_STAT, 32'h1);
        chk_irq(1'b0);
        wr(OFS_IRQ_MASK, 32'h0);
      end
    end
    // frozen machine: controls still follow requests
    repeat (2) step(1'b0, 1'b0);
    wr(OFS_IRQ_STAT, 32'hF);
    step(1'b0, 1'b0);
    wr(OFS_CTRL, 32'h1);
    step(1'b1, 1'b1);
    repeat (3) step(1'b1, 1'b0);
    step(1'b0, 1'b1);
    step(1'b0, 1'b0);
    rd(OFS_CTRL, 32'h1);
    rd(OFS_IRQ_STAT, 32'h8);
    wr(OFS_CTRL, 32'h0);
    repeat (3) step(1'b1, 1'b0);
    // second reset in mid-traffic
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (3) step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    summarize();
  end
endmodule // fcfsm_ctrl_test
